/* File: design/aawc_alert_window.sv */
// Purpose: configuration, limit registers and out-of-range flag logic of a converter
// Assumes: serial engine delivers pointer-selected accesses on the core clock
// Notes:   conversion results arrive as one-cycle done pulses on the same clock
`timescale 1ns/1ps
`include "aawc_consts.svh"

// Notes on behaviour
// - cycle code zero means automatic conversion off; reset value is zero
// - any non-zero cycle code starts repeated conversions without bus commands
// - interval is conversion time times 32 up to 2048 for codes 1 to 7
// - hold clear: a flag self-clears once back inside limit by more than margin
// - hold set: flags only clear when software writes one to them
// - flag enable bit gates the alert indicator in the result word
// - pin enable drives the alert pin; when clear the pin floats
// - polarity bit zero gives active low alert, one gives active high
// - reserved bits read zero; software writes zeros there
// - under-range limit raises under flag when result is below it
// - over-range limit raises over flag when result is above it
// - clear margin sets how far inside the limit a result must move
// - pointer two selects the read-write configuration register
// - pointers three, four, five select under, over and margin registers
// - status bits one and zero hold over and under flags, write one clears
// - with flag enable, result bit fifteen shows either flag set
module aawc_alert_window #(
    parameter int unsigned CONV_CYCLES = `AAWC_CONV_CYC
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    reset_n_i,
    input  wire aawc_pkg::aawc_reg_req_t reg_req_i,
    output logic [15:0]                  reg_rdata_o,
    input  wire aawc_pkg::aawc_conv_t    conv_i,
    output logic                         conv_start_o,
    output logic                         result_flag_o,
    output logic                         alert_o,
    output logic                         alert_oe_o
);

    // configuration and limit storage, reserved bits never stored
    logic [7:0]  cfg_q;
    logic [9:0]  under_q;
    logic [9:0]  over_q;
    logic [9:0]  margin_q;

    // flags and last result
    logic        over_flag_q;
    logic        under_flag_q;
    logic [9:0]  result_q;

    // decoded configuration fields
    logic [2:0]  cycle_code;
    logic        hold_en;
    logic        flag_en;
    logic        pin_en;
    logic        polarity;

    // per-conversion decisions
    logic        over_set;
    logic        under_set;
    logic        over_selfclr;
    logic        under_selfclr;
    logic        over_w1c;
    logic        under_w1c;
    logic        any_flag;

    // write strobe for one pointer value
    function automatic logic wr_hit(input aawc_pkg::aawc_reg_req_t req,
                                    input logic [2:0] ptr);
        wr_hit = req.wr && (req.ptr == ptr);
    endfunction

    // place a 10-bit value into a 16-bit word, reserved bits zero
    function automatic logic [15:0] pack_val(input logic [9:0] v);
        logic [15:0] w;
        w = 16'h0000;
        w[`AAWC_VAL_HI:`AAWC_VAL_LO] = v;
        pack_val = w;
    endfunction

    // configuration field decode
    assign cycle_code = cfg_q[`AAWC_CFG_CYC_HI:`AAWC_CFG_CYC_LO];
    assign hold_en    = cfg_q[`AAWC_CFG_HOLD];
    assign flag_en    = cfg_q[`AAWC_CFG_FLAG_EN];
    assign pin_en     = cfg_q[`AAWC_CFG_PIN_EN];
    assign polarity   = cfg_q[`AAWC_CFG_POL];

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cfg_q <= `AAWC_CFG_RESET;
        end else if (wr_hit(reg_req_i, `AAWC_PTR_CONFIG)) begin
            cfg_q <= reg_req_i.wdata[7:0] & `AAWC_CFG_WMASK;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            under_q <= 10'(`AAWC_UNDER_RESET >> `AAWC_VAL_LO);
        end else if (wr_hit(reg_req_i, `AAWC_PTR_UNDER)) begin
            under_q <= reg_req_i.wdata[`AAWC_VAL_HI:`AAWC_VAL_LO];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            over_q <= 10'(`AAWC_OVER_RESET >> `AAWC_VAL_LO);
        end else if (wr_hit(reg_req_i, `AAWC_PTR_OVER)) begin
            over_q <= reg_req_i.wdata[`AAWC_VAL_HI:`AAWC_VAL_LO];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            margin_q <= 10'(`AAWC_MARGIN_RESET >> `AAWC_VAL_LO);
        end else if (wr_hit(reg_req_i, `AAWC_PTR_MARGIN)) begin
            margin_q <= reg_req_i.wdata[`AAWC_VAL_HI:`AAWC_VAL_LO];
        end
    end

    aawc_conv_pacer u_pacer (
        .core_clk_i    (core_clk_i),
        .reset_n_i     (reset_n_i),
        .cycle_code_i  (cycle_code),
        .conv_cycles_i (24'(CONV_CYCLES)),
        .start_o       (conv_start_o)
    );

    // comparisons against the registers as they stand now
    always_comb begin
        over_set  = conv_i.done && (conv_i.value > over_q);
        under_set = conv_i.done && (conv_i.value < under_q);
        // sums in 11 bits so a large margin cannot wrap
        over_selfclr  = conv_i.done && !hold_en &&
                        ({1'b0, conv_i.value} + {1'b0, margin_q} < {1'b0, over_q});
        under_selfclr = conv_i.done && !hold_en &&
                        ({1'b0, conv_i.value} > {1'b0, under_q} + {1'b0, margin_q});
    end

    assign over_w1c  = wr_hit(reg_req_i, `AAWC_PTR_STATUS) &&
                       reg_req_i.wdata[`AAWC_ST_OVER];
    assign under_w1c = wr_hit(reg_req_i, `AAWC_PTR_STATUS) &&
                       reg_req_i.wdata[`AAWC_ST_UNDER];

    // over flag: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            over_flag_q <= 1'b0;
        end else if (over_set) begin
            over_flag_q <= 1'b1;
        // software clear works in both hold modes
        end else if (over_w1c || over_selfclr) begin
            over_flag_q <= 1'b0;
        end
    end

    // under flag: same priorities as the over flag
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            under_flag_q <= 1'b0;
        end else if (under_set) begin
            under_flag_q <= 1'b1;
        // software clear works in both hold modes
        end else if (under_w1c || under_selfclr) begin
            under_flag_q <= 1'b0;
        end
    end

    // last conversion value, shown at pointer zero
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            result_q <= 10'h000;
        end else if (conv_i.done) begin
            result_q <= conv_i.value;
        end
    end

    assign any_flag = over_flag_q | under_flag_q;

    // alert indicator of the result word
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            result_flag_o <= 1'b0;
        end else begin
            result_flag_o <= flag_en & any_flag;
        end
    end

    // alert pin level; registered so it never glitches on decode
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            alert_o <= 1'b1;
        end else begin
            alert_o <= polarity ? any_flag : ~any_flag;
        end
    end

    // pin drive enable; off means the pin floats
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            alert_oe_o <= 1'b0;
        end else begin
            alert_oe_o <= pin_en;
        end
    end

    // read data one cycle after the pointer; unused pointers read zero
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else begin
            case (reg_req_i.ptr)
                `AAWC_PTR_RESULT: begin
                    reg_rdata_o <= pack_val(result_q) |
                                   {flag_en & any_flag, 15'h0000};
                end
                `AAWC_PTR_STATUS: begin
                    reg_rdata_o <= {14'h0000, over_flag_q, under_flag_q};
                end
                `AAWC_PTR_CONFIG: begin
                    reg_rdata_o <= {8'h00, cfg_q};
                end
                `AAWC_PTR_UNDER: begin
                    reg_rdata_o <= pack_val(under_q);
                end
                `AAWC_PTR_OVER: begin
                    reg_rdata_o <= pack_val(over_q);
                end
                `AAWC_PTR_MARGIN: begin
                    reg_rdata_o <= pack_val(margin_q);
                end
                default: begin
                    reg_rdata_o <= 16'h0000;
                end
            endcase
        end
    end

endmodule

/* File: design/aawc_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts of the alert window block
// Assumes: included by bare name from design files only
// Notes:   definitions only, no logic
`ifndef AAWC_CONSTS_SVH
`define AAWC_CONSTS_SVH

// register pointer values
`define AAWC_PTR_RESULT     3'h0
`define AAWC_PTR_STATUS     3'h1
`define AAWC_PTR_CONFIG     3'h2
`define AAWC_PTR_UNDER      3'h3
`define AAWC_PTR_OVER       3'h4
`define AAWC_PTR_MARGIN     3'h5

// configuration field positions
`define AAWC_CFG_CYC_HI     7
`define AAWC_CFG_CYC_LO     5
`define AAWC_CFG_HOLD       4
`define AAWC_CFG_FLAG_EN    3
`define AAWC_CFG_PIN_EN     2
`define AAWC_CFG_POL        0
`define AAWC_CFG_WMASK      8'hFD

// 10-bit value field inside the 16-bit words
`define AAWC_VAL_HI         11
`define AAWC_VAL_LO         2
`define AAWC_RES_FLAG       15

// status flag positions
`define AAWC_ST_OVER        1
`define AAWC_ST_UNDER       0

// reset values
`define AAWC_CFG_RESET      8'h00
`define AAWC_UNDER_RESET    16'h0000
`define AAWC_OVER_RESET     16'h0FFF
`define AAWC_MARGIN_RESET   16'h0000

// timing: single conversion time and clock period in ns
`define AAWC_T_CONVERT_NS   1000
`define AAWC_CLK_PERIOD_NS  100
`define AAWC_CONV_CYC       ((`AAWC_T_CONVERT_NS + `AAWC_CLK_PERIOD_NS - 1) / `AAWC_CLK_PERIOD_NS)
// code 001 gives x32, so shift is code plus this offset
`define AAWC_SHIFT_OFFSET   4

`endif

/* File: design/aawc_pkg.sv */
// Purpose: shared types of the alert window block
// Assumes: constants live in aawc_consts.svh
// Notes:   nothing here is imported; use aawc_pkg::name
package aawc_pkg;

    // register access from the serial engine, pointer selected
    typedef struct packed {
        logic        wr;
        logic [2:0]  ptr;
        logic [15:0] wdata;
    } aawc_reg_req_t;

    // one completed conversion from the converter core
    typedef struct packed {
        logic        done;
        logic [9:0]  value;
    } aawc_conv_t;

    // pacer states
    typedef enum logic [0:0] {
        AAWC_PACE_IDLE,
        AAWC_PACE_RUN
    } aawc_pace_state_t;

endpackage

/* File: design/aawc_conv_pacer.sv */
// Purpose: paces automatic conversions from the cycle interval code
// Assumes: conv_cycles_i is the single conversion time in clock cycles
// Notes:   first start comes the cycle after a new non-zero code is seen
`timescale 1ns/1ps
`include "aawc_consts.svh"

module aawc_conv_pacer (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [2:0] cycle_code_i,
    input  wire logic [23:0] conv_cycles_i,
    output logic            start_o
);

    aawc_pkg::aawc_pace_state_t state_q;
    logic [2:0]  code_q;
    logic [23:0] count_q;

    // interval is the conversion time times 2^(code+4)
    function automatic logic [23:0] interval_of(input logic [2:0] code,
                                                input logic [23:0] base);
        logic [4:0] sh;
        sh = 5'(code) + 5'(`AAWC_SHIFT_OFFSET);
        interval_of = base << sh;
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_q <= aawc_pkg::AAWC_PACE_IDLE;
            code_q  <= 3'h0;
            count_q <= 24'h000000;
            start_o <= 1'b0;
        end else begin
            code_q  <= cycle_code_i;
            start_o <= 1'b0;
            case (state_q)
                aawc_pkg::AAWC_PACE_IDLE: begin
                    if (cycle_code_i != 3'h0) begin
                        state_q <= aawc_pkg::AAWC_PACE_RUN;
                        start_o <= 1'b1;
                        count_q <= interval_of(cycle_code_i, conv_cycles_i) - 24'h000001;
                    end
                end
                aawc_pkg::AAWC_PACE_RUN: begin
                    if (cycle_code_i == 3'h0) begin
                        state_q <= aawc_pkg::AAWC_PACE_IDLE;
                    end else if (cycle_code_i != code_q || count_q == 24'h000000) begin
                        // a changed non-zero code restarts the interval at once
                        start_o <= 1'b1;
                        count_q <= interval_of(cycle_code_i, conv_cycles_i) - 24'h000001;
                    end else begin
                        count_q <= count_q - 24'h000001;
                    end
                end
                default: begin
                    state_q <= aawc_pkg::AAWC_PACE_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: dv/aawc_sva.sv */
// Purpose: port checker of the alert window block
// Assumes: config is mirrored from bus writes to pointer two
// Notes:   interval check skips periods in which the code moved
`timescale 1ns/1ps
module aawc_sva #(
    parameter int unsigned CONV_CYCLES = 10
) (
    input wire logic                    core_clk_i,
    input wire logic                    reset_n_i,
    input wire aawc_pkg::aawc_reg_req_t reg_req_i,
    input wire logic [15:0]             reg_rdata_o,
    input wire aawc_pkg::aawc_conv_t    conv_i,
    input wire logic                    conv_start_o,
    input wire logic                    result_flag_o,
    input wire logic                    alert_o,
    input wire logic                    alert_oe_o
);
    logic [7:0]  cfg_q;
    logic [2:0]  ref_q;
    logic        st_q;
    logic [23:0] cnt_q;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // config mirror, reserved bit one dropped
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i)
            cfg_q <= 8'h00;
        else if (reg_req_i.wr && reg_req_i.ptr == 3'h2)
            cfg_q <= reg_req_i.wdata[7:0] & 8'hFD;
    end
    // cycles since last start; stale once the code moves
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || conv_start_o) begin
            cnt_q <= 24'h000001;
            ref_q <= cfg_q[7:5];
            st_q  <= reset_n_i;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
            st_q  <= st_q && (cfg_q[7:5] == ref_q);
        end
    end
    sequence s_new_code;
        reg_req_i.wr && reg_req_i.ptr == 3'h2 && reg_req_i.wdata[7:5] != 3'h0
            && reg_req_i.wdata[7:5] != cfg_q[7:5];
    endsequence
    a_cfg_read: assert property (!reg_req_i.wr && !$past(reg_req_i.wr) && reg_req_i.ptr == 3'h2
        |=> reg_rdata_o == {8'h00, cfg_q}) else $error("config read mismatch");
    a_rsv_zero: assert property ($past(reg_req_i.ptr) inside {3'h3, 3'h4, 3'h5}
        |-> reg_rdata_o[15:12] == 4'h0 && reg_rdata_o[1:0] == 2'h0) else $error("reserved set");
    a_idle_quiet: assert property (cfg_q[7:5] == 3'h0 && $past(cfg_q[7:5], 2) == 3'h0
        && $past(cfg_q[7:5]) == 3'h0 |-> !conv_start_o) else $error("start while off");
    a_code_start: assert property (s_new_code |-> ##2 conv_start_o)
        else $error("no start after code write");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start longer than one cycle");
    a_interval_len: assert property (conv_start_o && st_q && ref_q != 3'h0
        |-> cnt_q == (CONV_CYCLES << (32'(ref_q) + 4))) else $error("interval wrong");
    a_pin_oe: assert property ($stable(cfg_q) |-> alert_oe_o == cfg_q[2])
        else $error("pin enable mismatch");
    a_pol_level: assert property ($stable(cfg_q) && cfg_q[3] && cfg_q[2]
        |-> alert_o == (result_flag_o ? cfg_q[0] : !cfg_q[0])) else $error("alert level");
    a_flag_gate: assert property ($stable(cfg_q) && !cfg_q[3] |-> !result_flag_o)
        else $error("flag shown while gated");
endmodule

bind aawc_alert_window aawc_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .conv_i(conv_i), .conv_start_o(conv_start_o),
    .result_flag_o(result_flag_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o));

/* File: dv/aawc_bus_master.sv */
// Purpose: bus master model issuing pointer accesses
// Assumes: drives just after the falling edge
// Notes:   released write data is inverted so stale data never looks valid
`timescale 1ns/1ps
module aawc_bus_master (
    input  wire logic               core_clk_i,
    output aawc_pkg::aawc_reg_req_t req_o,
    output logic                    rd_vld_o
);
    initial begin
        req_o    = '0;
        rd_vld_o = 1'b0;
    end
    // callers keep reserved bits zero; words are sent as given
    task automatic wr(input logic [2:0] p, input logic [15:0] d);
        @(negedge core_clk_i);
        req_o <= '{wr: 1'b1, ptr: p, wdata: d};
        @(negedge core_clk_i);
        req_o.wr    <= 1'b0;
        req_o.wdata <= ~d;
    endtask
    // data is valid one cycle after the pointer
    task automatic rd(input logic [2:0] p);
        @(negedge core_clk_i);
        req_o.ptr <= p;
        rd_vld_o  <= 1'b1;
        @(negedge core_clk_i);
        rd_vld_o  <= 1'b0;
    endtask
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of the alert window block
// Assumes: one-cycle conversion time keeps pacing runs short
// Notes:   limits under 100, over 800, margin 20
`timescale 1ns/1ps
module tb_top;
    logic                    core_clk_i = 1'b0;
    logic                    reset_n_i = 1'b0;
    aawc_pkg::aawc_reg_req_t req;
    aawc_pkg::aawc_conv_t    conv = '0;
    logic [15:0]             rdata, v;
    logic                    start, rflag, alert, oe, rd_vld;
    logic [15:0]             exq[$];
    int                      failures = 0;
    int                      check_count = 0;
    int                      gap;
    always #50 core_clk_i = ~core_clk_i;
    aawc_bus_master bm (.core_clk_i(core_clk_i), .req_o(req), .rd_vld_o(rd_vld));
    aawc_alert_window #(.CONV_CYCLES(1)) uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .conv_i(conv), .conv_start_o(start),
        .result_flag_o(rflag), .alert_o(alert), .alert_oe_o(oe));
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // read words are matched against the oldest note
    always @(negedge core_clk_i) begin
        if (rd_vld === 1'b1) begin
            if (exq.size() == 0) begin
                failures++;
                $display("ERROR rdata expected none seen %h", rdata);
            end else
                chk("rdata", rdata, exq.pop_front());
        end
    end
    task automatic rd(input logic [2:0] p, input logic [15:0] e);
        exq.push_back(e);
        bm.rd(p);
    endtask
    // one conversion, then a cycle for the registered outputs
    task automatic cv(input logic [9:0] x);
        @(negedge core_clk_i);
        conv <= '{done: 1'b1, value: x};
        @(negedge core_clk_i);
        conv <= '{done: 1'b0, value: ~x};
        @(negedge core_clk_i);
    endtask
    task automatic pin(input logic f, input logic a, input logic o);
        chk("flag", {15'h0000, rflag}, {15'h0000, f});
        chk("alert", {15'h0000, alert}, {15'h0000, a});
        chk("oe", {15'h0000, oe}, {15'h0000, o});
    endtask
    // counts falling edges until a start pulse or the limit
    task automatic wstart(input int lim, input bit must);
        gap = 0;
        do begin
            @(negedge core_clk_i);
            gap++;
        end while (start !== 1'b1 && gap < lim);
        // a start that never came is a hang: count it and close the run
        if (must && start !== 1'b1) begin
            failures++;
            $display("ERROR start expected 1 seen %b", start);
            results();
        end
    endtask
    initial begin
        void'($urandom(51885));
        repeat (10) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        rd(3'h2, 16'h0000);
        rd(3'h3, 16'h0000);
        rd(3'h4, 16'h0FFC);
        rd(3'h5, 16'h0000);
        rd(3'h1, 16'h0000);
        bm.wr(3'h2, 16'h001D); // reserved bit one written as zero
        rd(3'h2, 16'h001D);
        for (int p = 3; p < 6; p++) begin
            v = 16'($urandom) & 16'h0FFC; // reserved bits kept zero
            bm.wr(3'(p), v);
            rd(3'(p), v & 16'h0FFC);
        end
        bm.wr(3'h3, 16'h0190);
        bm.wr(3'h4, 16'h0C80);
        bm.wr(3'h5, 16'h0050);
        for (int pol = 0; pol < 2; pol++) begin
            bm.wr(3'h2, 16'h000C | 16'(pol));
            cv(10'd900);
            rd(3'h1, 16'h0002);
            rd(3'h0, 16'h8E10);
            pin(1'b1, 1'(pol), 1'b1);
            cv(10'd780);
            rd(3'h1, 16'h0002);
            cv(10'd779);
            rd(3'h1, 16'h0000);
            pin(1'b0, !1'(pol), 1'b1);
            cv(10'd99);
            rd(3'h1, 16'h0001);
            cv(10'd120);
            rd(3'h1, 16'h0001);
            cv(10'd121);
            rd(3'h1, 16'h0000);
        end
        bm.wr(3'h2, 16'h0014);
        cv(10'd900);
        cv(10'd0);
        cv(10'd500);
        rd(3'h1, 16'h0003);
        rd(3'h0, 16'h07D0);
        pin(1'b0, 1'b0, 1'b1);
        bm.wr(3'h1, 16'h0002);
        rd(3'h1, 16'h0001);
        bm.wr(3'h1, 16'h0001);
        rd(3'h1, 16'h0000);
        for (int c = 1; c < 8; c++) begin
            bm.wr(3'h2, 16'(c << 5));
            wstart(8, 1'b1);
            chk("first", 16'(gap), 16'h0001);
            wstart(4100, 1'b1);
            chk("gap", 16'(gap), 16'(32 << (c - 1)));
        end
        bm.wr(3'h2, 16'h0000);
        wstart(3000, 1'b0);
        chk("idle", 16'(gap), 16'(3000));
        chk("oe", {15'h0000, oe}, 16'h0000);
        results();
    end
endmodule
